// ==== pkg/kam_defs.svh ====
// Register offsets, field positions and reset values of the key/match block
`ifndef KAM_DEFS_SVH
`define KAM_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define KAM_OFF_KEY_CTRL   8'h98
`define KAM_OFF_MATCH_EN   8'h9C
`define KAM_OFF_MATCH_AD0  8'hA0
`define KAM_OFF_MATCH_AD1  8'hA4
`define KAM_OFF_KEY_IRQ    8'hA8
`define KAM_OFF_STACK_PTR  8'hAC

// ****************************************
// Reset values
// ****************************************
`define KAM_RST_KEY_CTRL   8'h00
`define KAM_RST_MATCH_EN   2'h0
`define KAM_RST_MATCH_AD   20'h00000
`define KAM_RST_KEY_LVL    3'h0
`define KAM_RST_STACK_PTR  16'h0000

// ****************************************
// Field positions
// ****************************************
`define KAM_KEY_LVL_MSB    2
`define KAM_KEY_FLAG_BIT   3

// ****************************************
// Fixed acknowledge address and return offsets
// ****************************************
`define KAM_ACK_ADDR       20'h00000
`define KAM_RET_LONG       20'h00002
`define KAM_RET_SHORT      20'h00001

`endif

// ==== pkg/kam_pkg.sv ====
// Types shared by the key input and address match interrupt block
package kam_pkg;

	typedef struct packed {
		logic pl;
		logic en;
	} kam_key_bit_type;

	typedef kam_key_bit_type [3:0] kam_key_ctrl_type;

	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} kam_bus_type;

	// Instruction about to execute
	typedef struct packed {
		logic        valid;
		logic        long_op;
		logic [19:0] pc;
	} kam_fetch_type;

	// Data read issued by the core
	typedef struct packed {
		logic        rd;
		logic [19:0] addr;
	} kam_cpu_rd_type;

endpackage

// ==== rtl/kam_irq.sv ====
// Key input interrupt and two-channel address match interrupt
//
// Behaviour
// - An active edge on any of the four key pins raises one key request.
// - Each key pin has an enable bit; 0 leaves it unused, 1 uses it.
// - Each key pin has a polarity bit; 0 falling edge, 1 rising edge.
// - A key request can wake the device from wait and from stop.
// - While one enabled pin sits at its active level, others give no request.
// - A match request is raised just before the instruction at a match address.
// - Channel 0 pairs enable bit 0 with address 0, channel 1 bit 1 with address 1.
// - The match request ignores the global enable flag and the priority level.
// - The pushed address is match plus two for long opcodes, else plus one.
// - The acknowledge read of the fixed address returns number and level and clears the flag.
// - Any read of the fixed address clears the highest-priority enabled flag.
// - The stack pointer is zero after reset; software loads it before use.
// - Changing key enable or polarity may set the key flag; software clears it.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`include "kam_defs.svh"
module kam_irq #(
	parameter int          NKEY       = 4,
	parameter int          AW         = 20,
	parameter logic [4:0]  KEY_VECTOR = 5'h0D
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Key pins
	input  wire logic [NKEY-1:0]       key_pin,
	// Register port
	input  wire kam_pkg::kam_bus_type  bus,
	output logic [31:0]                rd_data_q,
	// Core fetch and data read
	input  wire kam_pkg::kam_fetch_type fetch,
	input  wire kam_pkg::kam_cpu_rd_type cpu_rd,
	input  wire logic                  match_ack,
	output logic [7:0]                 ack_data_q,
	// Requests, return address and stack pointer
	output logic                       key_irq_q,
	output logic                       wake_q,
	output logic                       match_req_q,
	output logic [AW-1:0]              push_addr_q,
	output logic [15:0]                stack_ptr_q
);
	import kam_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	initial begin
		if (NKEY != 4) $error("kam_irq: NKEY must be 4");
		if (AW != 20) $error("kam_irq: AW must be 20");
	end

	// ****************************************
	// Registers
	// ****************************************
	kam_key_ctrl_type key_pin_control_q;
	logic [1:0]       match_channel_enables_q;
	logic [AW-1:0]    match_address_register_q [2];
	logic [2:0]       key_level_q;
	logic             pending_request_flag_q;

	logic wr_key_ctrl;
	logic wr_match_en;
	logic wr_match_ad0;
	logic wr_match_ad1;
	logic wr_key_irq;
	logic wr_stack_ptr;

	assign wr_key_ctrl  = bus.wr && bus.addr == `KAM_OFF_KEY_CTRL;
	assign wr_match_en  = bus.wr && bus.addr == `KAM_OFF_MATCH_EN;
	assign wr_match_ad0 = bus.wr && bus.addr == `KAM_OFF_MATCH_AD0;
	assign wr_match_ad1 = bus.wr && bus.addr == `KAM_OFF_MATCH_AD1;
	assign wr_key_irq   = bus.wr && bus.addr == `KAM_OFF_KEY_IRQ;
	assign wr_stack_ptr = bus.wr && bus.addr == `KAM_OFF_STACK_PTR;

	always_ff @(posedge clk) begin
		if (rst) begin
			key_pin_control_q <= `KAM_RST_KEY_CTRL;
		end else if (wr_key_ctrl) begin
			key_pin_control_q <= bus.wdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			match_channel_enables_q <= `KAM_RST_MATCH_EN;
		end else if (wr_match_en) begin
			match_channel_enables_q <= bus.wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			match_address_register_q[0] <= `KAM_RST_MATCH_AD;
			match_address_register_q[1] <= `KAM_RST_MATCH_AD;
		end else begin
			if (wr_match_ad0) begin
				match_address_register_q[0] <= bus.wdata[AW-1:0];
			end
			if (wr_match_ad1) begin
				match_address_register_q[1] <= bus.wdata[AW-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			key_level_q <= `KAM_RST_KEY_LVL;
		end else if (wr_key_irq) begin
			key_level_q <= bus.wdata[`KAM_KEY_LVL_MSB:0];
		end
	end

	// Zero at reset; a stray acknowledge before software loads it is fatal
	always_ff @(posedge clk) begin
		if (rst) begin
			stack_ptr_q <= `KAM_RST_STACK_PTR;
		end else if (wr_stack_ptr) begin
			stack_ptr_q <= bus.wdata[15:0];
		end
	end

	// ****************************************
	// Key input detection
	// ****************************************
	logic [NKEY-1:0] key_sync;
	logic [NKEY-1:0] key_active;
	logic            key_any;
	logic            key_any_q;
	logic            key_evt;

	kam_sync #(
		.W        (NKEY)
	) u_key_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (key_pin),
		.sync_out (key_sync)
	);

	// Active level per enabled pin: high for rising, low for falling
	always_comb begin
		for (int i = 0; i < NKEY; i++) begin
			key_active[i] = key_pin_control_q[i].en
				& ~(key_sync[i] ^ key_pin_control_q[i].pl);
		end
	end

	// One OR of all pins: a pin held active masks the others
	assign key_any = |key_active;
	assign key_evt = key_any & ~key_any_q;

	// Config writes can move key_any too, so they may set the flag
	always_ff @(posedge clk) begin
		if (rst) begin
			key_any_q <= 1'b0;
		end else begin
			key_any_q <= key_any;
		end
	end

	// ****************************************
	// Key request flag and acknowledge read
	// ****************************************
	logic ack_hit;
	logic key_enabled;
	logic key_sw_clr;
	logic key_flag_d;

	assign ack_hit     = cpu_rd.rd && cpu_rd.addr == `KAM_ACK_ADDR;
	assign key_enabled = key_level_q != `KAM_RST_KEY_LVL;
	assign key_sw_clr  = wr_key_irq && !bus.wdata[`KAM_KEY_FLAG_BIT];

	// Set wins over both software clear and acknowledge clear
	always_comb begin
		key_flag_d = pending_request_flag_q;
		if (key_sw_clr) begin
			key_flag_d = 1'b0;
		end
		if (ack_hit && key_enabled && pending_request_flag_q) begin
			key_flag_d = 1'b0;
		end
		if (key_evt) begin
			key_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pending_request_flag_q <= 1'b0;
		end else begin
			pending_request_flag_q <= key_flag_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			key_irq_q <= 1'b0;
		end else begin
			key_irq_q <= key_flag_d & key_enabled;
		end
	end

	// Wake ignores the level so a masked key still ends wait or stop
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= key_flag_d;
		end
	end

	// Interrupt number and level for the acknowledge sequence
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_data_q <= 8'h00;
		end else if (ack_hit) begin
			ack_data_q <= {KEY_VECTOR, key_level_q};
		end
	end

	// ****************************************
	// Address match
	// ****************************************
	logic [1:0] chan_hit;
	logic       match_any;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		kam_match_chan #(
			.AW          (AW)
		) u_chan (
			.enable      (match_channel_enables_q[c]),
			.match_addr  (match_address_register_q[c]),
			.fetch_valid (fetch.valid),
			.fetch_pc    (fetch.pc),
			.hit         (chan_hit[c])
		);
	end

	// No interrupt-enable or priority input: only the channel enable bits gate it
	assign match_any = |chan_hit;

	always_ff @(posedge clk) begin
		if (rst) begin
			match_req_q <= 1'b0;
		end else if (match_any) begin
			match_req_q <= 1'b1;
		end else if (match_ack) begin
			match_req_q <= 1'b0;
		end
	end

	// Stacked PC is not a usable return address; the handler must fix it
	always_ff @(posedge clk) begin
		if (rst) begin
			push_addr_q <= `KAM_RST_MATCH_AD;
		end else if (match_any) begin
			push_addr_q <= fetch.pc + (fetch.long_op ?
				`KAM_RET_LONG : `KAM_RET_SHORT);
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_q <= 32'h00000000;
		end else if (bus.rd) begin
			case (bus.addr)
				`KAM_OFF_KEY_CTRL: begin
					rd_data_q <= {24'h000000, key_pin_control_q};
				end
				`KAM_OFF_MATCH_EN: begin
					rd_data_q <= {30'h00000000, match_channel_enables_q};
				end
				`KAM_OFF_MATCH_AD0: begin
					rd_data_q <= {12'h000, match_address_register_q[0]};
				end
				`KAM_OFF_MATCH_AD1: begin
					rd_data_q <= {12'h000, match_address_register_q[1]};
				end
				`KAM_OFF_KEY_IRQ: begin
					rd_data_q <= {28'h0000000, pending_request_flag_q,
						key_level_q};
				end
				`KAM_OFF_STACK_PTR: begin
					rd_data_q <= {16'h0000, stack_ptr_q};
				end
				default: begin
					rd_data_q <= 32'h00000000;
				end
			endcase
		end else begin
			rd_data_q <= 32'h00000000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_key_edge_sets: assert property (
		key_evt |=> pending_request_flag_q && wake_q
	) else $error("key edge did not set the key flag");

	a_key_no_spurious: assert property (
		!pending_request_flag_q && !key_evt |=> !pending_request_flag_q
	) else $error("key flag set without a combined edge");

	a_key_disabled_pin: assert property (
		key_pin_control_q == `KAM_RST_KEY_CTRL |-> !key_any
	) else $error("disabled pins still seen as active");

	a_key_polarity: assert property (
		key_pin_control_q[0].en && key_pin_control_q[0].pl
			&& key_sync[0] |-> key_any
	) else $error("rising polarity pin high not active");

	a_wake_follows: assert property (
		wake_q |-> $past(key_flag_d)
	) else $error("wake output not tied to key flag");

	a_match_fires: assert property (
		fetch.valid && match_channel_enables_q[1]
			&& fetch.pc == match_address_register_q[1]
			|=> match_req_q
	) else $error("enabled match channel did not fire");

	a_match_gated: assert property (
		match_channel_enables_q == `KAM_RST_MATCH_EN && !match_req_q
			|=> !match_req_q
	) else $error("match request with both channels off");

	a_push_addr: assert property (
		match_any |=> push_addr_q == $past(fetch.pc)
			+ ($past(fetch.long_op) ? `KAM_RET_LONG : `KAM_RET_SHORT)
	) else $error("wrong pushed return address");

	a_ack_clears: assert property (
		ack_hit && key_enabled && !key_evt |=> !pending_request_flag_q
	) else $error("acknowledge read left the key flag set");

	a_ack_data: assert property (
		ack_hit |=> ack_data_q == {KEY_VECTOR, $past(key_level_q)}
	) else $error("acknowledge data wrong");

	a_sp_reset: assert property (
		$past(rst) |-> stack_ptr_q == `KAM_RST_STACK_PTR
	) else $error("stack pointer not zero after reset");

	a_sync_delay: assert property (
		key_pin == 4'hF [*3] |-> key_sync == 4'hF
	) else $error("key pins not through two flops");

	c_key_wake: cover property (key_evt ##1 wake_q);
	c_key_ack: cover property (key_irq_q ##[1:20] ack_hit);
	c_match_long: cover property (match_any && fetch.long_op);
	c_match_both: cover property (chan_hit == 2'h3);
endmodule

// ==== rtl/kam_match_chan.sv ====
// One address match channel: compares the next fetch address
`timescale 1ns/10ps
module kam_match_chan #(
	parameter int AW = 20
) (
	// Configuration
	input  wire logic          enable,
	input  wire logic [AW-1:0] match_addr,
	// Fetch
	input  wire logic          fetch_valid,
	input  wire logic [AW-1:0] fetch_pc,
	// Result
	output logic               hit
);
	initial begin
		if (AW < 1) $error("kam_match_chan: AW must be at least 1");
	end

	assign hit = enable & fetch_valid & (fetch_pc == match_addr);
endmodule

// ==== rtl/kam_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module kam_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	initial begin
		if (W < 1) $error("kam_sync: W must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ==== tb/kam_irq_test.sv ====
// Self-checking bench for the key input and address match interrupt block
`timescale 1ns/10ps
`include "kam_defs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module kam_irq_test;
	import kam_pkg::*;
	// Arbitrary vector number
	localparam logic [4:0] KV = 5'h0D;
	logic           clk = 1'b0;
	logic           rst = 1'b1;
	kam_bus_type    bus = '0;
	kam_fetch_type  fetch = '0;
	kam_cpu_rd_type cpu_rd = '0;
	logic           match_ack = 1'b0;
	logic [3:0]     press = 4'h0;
	logic [3:0]     key_pin;
	logic [31:0]    rd_data_q;
	logic [7:0]     ack_data_q;
	logic           key_irq_q;
	logic           wake_q;
	logic           match_req_q;
	logic [19:0]    push_addr_q;
	logic [15:0]    stack_ptr_q;
	logic [31:0]    v;
	int             failures = 0;
	int             num_checks = 0;

	kam_keys i_kam_keys (.press(press), .key_pin(key_pin));
	kam_irq #(.KEY_VECTOR(KV)) i_kam_irq (
		.clk(clk), .rst(rst), .key_pin(key_pin), .bus(bus),
		.rd_data_q(rd_data_q), .fetch(fetch), .cpu_rd(cpu_rd),
		.match_ack(match_ack), .ack_data_q(ack_data_q),
		.key_irq_q(key_irq_q), .wake_q(wake_q), .match_req_q(match_req_q),
		.push_addr_q(push_addr_q), .stack_ptr_q(stack_ptr_q));

	initial begin
		forever #2 clk = ~clk;
	end

	// ****************************************
	// Bus and pin drivers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rd_data_q;
	endtask
	// Keys need three stable clocks; six leaves margin for the syncs
	task automatic pins(input logic [3:0] lvl);
		@(posedge clk);
		press <= ~lvl;
		repeat (6) @(posedge clk);
		#1;
	endtask
	// Level 3, flag bit written 0 to clear it
	task automatic clr;
		wr(`KAM_OFF_KEY_IRQ, 32'h3);
	endtask
	task automatic cpu(input logic [19:0] a);
		@(posedge clk);
		cpu_rd <= '{rd: 1'b1, addr: a};
		@(posedge clk);
		cpu_rd.rd <= 1'b0;
		#1;
	endtask
	task automatic fetch_at(input logic [19:0] a, input logic lo);
		@(posedge clk);
		fetch <= '{valid: 1'b1, long_op: lo, pc: a};
		@(posedge clk);
		fetch.valid <= 1'b0;
		#1;
	endtask
	task automatic ack;
		@(posedge clk);
		match_ack <= 1'b1;
		@(posedge clk);
		match_ack <= 1'b0;
		#1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset;
		`CHK(stack_ptr_q, 16'h0000);
		rd(`KAM_OFF_KEY_CTRL, v);
		`CHK(v, 32'h0);
		rd(`KAM_OFF_MATCH_EN, v);
		`CHK(v, 32'h0);
		rd(8'h50, v);
		`CHK(v, 32'h0);
		wr(`KAM_OFF_STACK_PTR, 32'h1234);
		rd(`KAM_OFF_STACK_PTR, v);
		`CHK(v, 32'h1234);
		`CHK(stack_ptr_q, 16'h1234);
		// Mid-run reset must bring the stack pointer back to zero
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(stack_ptr_q, 16'h0000);
		$display("test_reset done");
	endtask

	task automatic test_edges;
		logic [3:0] lvl;
		for (int i = 0; i < 4; i++) begin
			for (int p = 0; p < 2; p++) begin
				lvl = 4'hF;
				lvl[i] = ~p[0];
				wr(`KAM_OFF_KEY_CTRL, (32'h1 | (32'(p) << 1)) << (2 * i));
				pins(lvl);
				// Rising select on a high pin makes it active at once
				`CHK(wake_q, p[0]);
				clr;
				lvl[i] = p[0];
				pins(lvl);
				`CHK(wake_q, 1'b1);
				`CHK(key_irq_q, 1'b1);
				clr;
				pins(lvl);
				`CHK(wake_q, 1'b0);
				pins(4'hF);
			end
		end
		$display("test_edges done");
	endtask

	task automatic test_gating;
		wr(`KAM_OFF_KEY_CTRL, 32'h04);
		pins(4'hF);
		clr;
		rd(`KAM_OFF_KEY_IRQ, v);
		`CHK(v, 32'h3);
		pins(4'hE);
		`CHK(wake_q, 1'b0);
		pins(4'hC);
		`CHK(wake_q, 1'b1);
		pins(4'hF);
		wr(`KAM_OFF_KEY_CTRL, 32'h05);
		pins(4'hF);
		clr;
		pins(4'hE);
		`CHK(wake_q, 1'b1);
		clr;
		pins(4'hC);
		`CHK(wake_q, 1'b0);
		pins(4'hD);
		`CHK(wake_q, 1'b0);
		pins(4'hF);
		pins(4'hE);
		`CHK(wake_q, 1'b1);
		rd(`KAM_OFF_KEY_CTRL, v);
		`CHK(v, 32'h05);
		pins(4'hF);
		$display("test_gating done");
	endtask

	task automatic test_ack;
		wr(`KAM_OFF_KEY_CTRL, 32'h01);
		pins(4'hF);
		clr;
		pins(4'hE);
		rd(`KAM_OFF_KEY_IRQ, v);
		`CHK(v, 32'hB);
		cpu(20'h00001);
		`CHK(key_irq_q, 1'b1);
		cpu(`KAM_ACK_ADDR);
		`CHK(ack_data_q, {KV, 3'h3});
		`CHK(key_irq_q, 1'b0);
		`CHK(wake_q, 1'b0);
		pins(4'hF);
		$display("test_ack done");
	endtask

	task automatic test_match;
		wr(`KAM_OFF_MATCH_AD0, 32'h01234);
		wr(`KAM_OFF_MATCH_AD1, 32'h0ABCD);
		wr(`KAM_OFF_MATCH_EN, 32'h1);
		rd(`KAM_OFF_MATCH_AD0, v);
		`CHK(v, 32'h01234);
		fetch_at(20'h0ABCD, 1'b1);
		`CHK(match_req_q, 1'b0);
		fetch_at(20'h01234, 1'b1);
		`CHK(match_req_q, 1'b1);
		`CHK(push_addr_q, 20'h01236);
		repeat (3) @(posedge clk);
		#1 `CHK(match_req_q, 1'b1);
		ack;
		`CHK(match_req_q, 1'b0);
		// Key level 0 stands in for a masked core; match must still fire
		wr(`KAM_OFF_KEY_IRQ, 32'h0);
		wr(`KAM_OFF_MATCH_EN, 32'h3);
		fetch_at(20'h0ABCD, 1'b0);
		`CHK(match_req_q, 1'b1);
		`CHK(push_addr_q, 20'h0ABCE);
		ack;
		$display("test_match done");
	endtask

	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#100000;
		failures++;
		give_verdict;
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		test_reset;
		test_edges;
		test_gating;
		test_ack;
		test_match;
		give_verdict;
	end
endmodule

// ==== tb/kam_keys.sv ====
// Model of the four key switches that sit on the key pins
`timescale 1ns/10ps
module kam_keys (
	// Switch state, 1 = pressed
	input  wire logic [3:0] press,
	// Pin levels seen by the device
	output logic      [3:0] key_pin
);
	// Pressed pulls the pin low, open leaves it on its pull-up
	// Off-edge delay so pin changes are unrelated to the core clock
	initial key_pin = 4'hF;
	always @(press) key_pin <= #1.3 ~press;
endmodule
